// ===== bench/core_agent.sv
`timescale 1ns/1ps
// Purpose: instruction-unit stand-in that issues decoder requests
// Assumes: request taken at the next edge, answer stands one cycle after
// Notes: leaves an idle cycle between requests
module core_agent
	import dmem_pkg::*;
(
	input wire logic core_clk,
	output dmem_pkg::dreq_s req,
	input wire dmem_pkg::dresp_s resp
);
	import dmem_pkg::*;
	// idle request from time zero so nothing is taken during reset
	initial req = '0;
	////////////////////////////////////////////////////////////////////
	// one request, then idle; the answer is read once its edge has landed
	task automatic xfer(input dreq_s r, output dresp_s q);
		@(posedge core_clk);
		req <= r;
		@(posedge core_clk);
		req <= '0;
		#1 q = resp;
	endtask
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
// Purpose: self-checking bench for the data-memory decoder
// Assumes: zero-wait bus slave, answer one edge after each request
// Notes: register reset values first, then table rows, paging, flash and reset cases
module tb;
	import dmem_pkg::*;
	typedef struct {acc_kind_e k; logic w; logic [7:0] a, d; logic i;
		logic [15:0] x; logic [7:0] e; logic s;} row_s;
	logic core_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'b010;
	dreq_s req, r;
	dresp_s resp, p;
	int mismatches = 0, samples_checked = 0;
	row_s rows[19];
	assign hready = hreadyout;
	dmem_decoder i_dmem_decoder (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.req(req), .resp(resp));
	core_agent i_core_agent (.core_clk(core_clk), .req(req), .resp(resp));
	initial forever #10 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask
	// bounded wait for hready high at a rising edge; read data taken there
	task automatic hwait();
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
			q = hrdata;
		end while (hready !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			complete_run();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		hsel <= 1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		hwait();
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		hwait();
	endtask
	task automatic op(input acc_kind_e k, input logic w, input logic [7:0] a,
		input logic [7:0] d, input logic p16, input logic [15:0] x);
		r = '{kind: k, wr: w, addr: a, wdata: d, use_idx_one: 1'b0, ptr16: p16, xaddr: x};
		i_core_agent.xfer(r, p);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		rows = '{
			'{ACC_DIRECT, 1, 8'h30, 8'h5A, 0, 16'h0, 8'h00, 0},
			'{ACC_DIRECT, 0, 8'h30, 8'h00, 0, 16'h0, 8'h5A, 0},
			'{ACC_DIRECT, 1, 8'h00, 8'h30, 0, 16'h0, 8'h00, 0},
			'{ACC_INDIRECT, 0, 8'h00, 8'h00, 0, 16'h0, 8'h5A, 0},
			'{ACC_DIRECT, 1, 8'h01, 8'h90, 0, 16'h0, 8'h00, 0},
			'{ACC_INDIRECT, 1, 8'h00, 8'hA5, 1, 16'h0, 8'h00, 0},
			'{ACC_DIRECT, 1, 8'h90, 8'h3C, 0, 16'h0, 8'h00, 1},
			'{ACC_DIRECT, 0, 8'h90, 8'h00, 0, 16'h0, 8'h00, 1},
			'{ACC_INDIRECT, 0, 8'h00, 8'h00, 1, 16'h0, 8'hA5, 0},
			'{ACC_DIRECT, 1, 8'h22, 8'h08, 0, 16'h0, 8'h00, 0},
			'{ACC_BIT, 0, 8'h13, 8'h00, 0, 16'h0, 8'h01, 0},
			'{ACC_BIT, 1, 8'h12, 8'h01, 0, 16'h0, 8'h00, 0},
			'{ACC_DIRECT, 0, 8'h22, 8'h00, 0, 16'h0, 8'h0C, 0},
			'{ACC_BIT, 0, 8'h88, 8'h00, 0, 16'h0, 8'h00, 1},
			'{ACC_PUSH, 1, 8'h00, 8'h77, 0, 16'h0, 8'h00, 0},
			'{ACC_DIRECT, 0, 8'h08, 8'h00, 0, 16'h0, 8'h77, 0},
			'{ACC_POP, 0, 8'h00, 8'h00, 0, 16'h0, 8'h77, 0},
			'{ACC_XMOVE, 1, 8'h00, 8'h3C, 0, 16'h0123, 8'h00, 0},
			'{ACC_XMOVE, 0, 8'h00, 8'h00, 0, 16'h0123, 8'h3C, 0}};
		repeat (4) @(posedge core_clk);
		rst_n <= 1;
		// register reset values and an unmapped word
		bus(0, OFS_SP, 0); chk("sp", 16'h0007, q[15:0]);
		bus(0, OFS_CTRL, 0); chk("psw", 16'h0000, q[15:0]);
		bus(0, OFS_STAT, 0); chk("base", 16'h0000, {8'h0, q[7:0]});
		bus(0, 8'h10, 0); chk("unmapped", 16'h0000, q[15:0]);
		$display("test done: reset values");
		// table of routed accesses, bank zero active
		foreach (rows[j]) begin
			r = '{kind: rows[j].k, wr: rows[j].w, addr: rows[j].a, wdata: rows[j].d,
				use_idx_one: rows[j].i, ptr16: 1'b1, xaddr: rows[j].x};
			i_core_agent.xfer(r, p);
			chk("valid", 16'h0001, {15'h0, p.valid});
			chk("sfr_sel", {15'h0, rows[j].s}, {15'h0, p.sfr_sel});
			if (rows[j].s) chk("sfr_addr", {8'h0, rows[j].a & 8'hF8}, {8'h0, p.sfr_addr});
			if (!rows[j].w) chk("rdata", {8'h0, rows[j].e},
				{8'h0, rows[j].k == ACC_BIT ? {7'h0, p.rdata[0]} : p.rdata});
		end
		$display("test done: table");
		bus(0, OFS_SP, 0); chk("sp after pop", 16'h0007, q[15:0]);
		// 8-bit external pointer takes upper byte bits 10:8 from the page field, the rest zero
		bus(1, OFS_PAGE, 8'h01);
		op(ACC_XMOVE, 1'b0, 8'h23, 8'h00, 1'b0, 16'h0);
		chk("paged read", 16'h003C, {8'h0, p.rdata});
		// bank three: base 0x18, its index register zero shows in status
		bus(1, OFS_CTRL, 8'h18);
		op(ACC_DIRECT, 1'b1, 8'h18, 8'h40, 1'b0, 16'h0);
		bus(0, OFS_STAT, 0); chk("status", 16'h4018, q[15:0]);
		// flash redirect of external writes
		bus(1, OFS_PAGE, 8'h09);
		op(ACC_XMOVE, 1'b1, 8'h55, 8'h11, 1'b0, 16'h0);
		chk("flash_wr", 16'h0001, {15'h0, p.flash_wr});
		chk("flash_addr", 16'h0155, p.flash_addr);
		$display("test done: page, bank, flash");
		// move the stack pointer off its reset value so the reset has something to undo
		bus(1, OFS_SP, 8'h40);
		bus(0, OFS_SP, 0); chk("sp written", 16'h0040, q[15:0]);
		// second reset in mid-run keeps RAM but restores registers
		@(posedge core_clk);
		rst_n <= 0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1;
		bus(0, OFS_SP, 0); chk("sp again", 16'h0007, q[15:0]);
		bus(0, OFS_CTRL, 0); chk("psw again", 16'h0000, q[15:0]);
		bus(0, OFS_PAGE, 0); chk("page again", 16'h0000, q[15:0]);
		r = '{kind: ACC_DIRECT, wr: 1'b0, addr: 8'h30, wdata: 8'h0, use_idx_one: 1'b0,
			ptr16: 1'b0, xaddr: 16'h0};
		i_core_agent.xfer(r, p);
		chk("kept ram", 16'h005A, {8'h0, p.rdata});
		$display("test done: mid-run reset");
		complete_run();
	end
endmodule

// ===== hdl/ahb_regs.sv
`timescale 1ns/1ps
// Purpose: AHB-Lite slave, zero wait state, always OKAY
// Assumes: single word transfers only
// Notes: presents a one-cycle write strobe and a read index
module ahb_regs (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [31:0] rd_word,
	output logic [7:0] rd_ofs,
	output logic wr_stb,
	output logic [7:0] wr_ofs,
	output logic [31:0] wr_data
);
	logic wr_pend_r;
	logic [7:0] ofs_r;

	// address phase capture; hsize is always word here
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wr_pend_r <= 1'b0;
			ofs_r <= 8'h00;
		end else if (hready) begin
			wr_pend_r <= hsel && htrans[1] && hwrite;
			ofs_r <= haddr[7:0];
		end
	end

	assign rd_ofs = haddr[7:0];
	assign wr_stb = wr_pend_r;
	assign wr_ofs = ofs_r;
	assign wr_data = hwdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// read data registered so it stands in the data phase
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata <= rd_word;
		end
	end
endmodule

// ===== hdl/dmem_decoder.sv
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
// Purpose: data-memory decoder with internal RAM, banks, stack and extended_data_ram
// Assumes: one request per cycle from the instruction unit
// Notes: answers one cycle after the request
// Operation
// - 256 bytes internal RAM at 0x00-0xFF
// - lower half reached direct and indirect
// - upper half indirect or stack only, separate store
// - direct above 0x7F goes to special registers
// - indirect above 0x7F hits upper RAM
// - 0x00-0x1F are four eight-register banks
// - one bank active, chosen by status bits
// - indirect pointer from index register zero/one
// - 0x20-0x2F also 128 addressable bits
// - bit address = byte offset*8 + bit
// - bit versus byte chosen by operand type
// - push increments pointer then stores
// - reset loads stack pointer with 0x07
// - stack anywhere, up to 256 deep
// - extra RAM only via external moves
// - external writes may program flash instead
// - no instruction fetch from data memory
// - program space spans 64 KB
// - reset keeps RAM contents intact
// - page field gives upper address byte; here a 3-bit page gives bits 10:8 only, bits 15:11 zero
module dmem_decoder
	import dmem_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire dmem_pkg::dreq_s req,
	output dmem_pkg::dresp_s resp
);
	import dmem_pkg::*;

	logic [7:0] iram [0:255];
	logic [7:0] extended_data_ram [0:EXTENDED_DATA_RAM_DEPTH-1];
	logic [7:0] psw_r;
	logic [7:0] sp_r;
	logic [2:0] page_r;
	logic xwr_flash_r;
	logic [7:0] rd_ofs;
	logic wr_stb;
	logic [7:0] wr_ofs;
	logic [31:0] wr_data;
	logic [31:0] rd_word;
	logic [7:0] bank_base;
	logic [7:0] ptr;
	logic [7:0] eff_addr;
	logic to_sfr;
	logic iram_wr;
	logic [7:0] iram_wdata;
	logic [15:0] xa;
	logic [7:0] sp_nxt;
	logic bit_val;
	logic [7:0] bit_byte;
	dresp_s resp_nxt;

	// byte address holding a given bit address of the bit window
	// sixteen bytes as bits
	function automatic logic [7:0] bit_to_byte(input logic [7:0] b);
		bit_to_byte = BIT_BASE + {4'h0, b[6:3]};
	endfunction

	////////////////////////////////////////////////////////////////////
	// register bus
	ahb_regs u_bus (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.rd_word(rd_word),
		.rd_ofs(rd_ofs),
		.wr_stb(wr_stb),
		.wr_ofs(wr_ofs),
		.wr_data(wr_data)
	);

	// read mux; unmapped offsets read zero
	always_comb begin
		case (rd_ofs)
			OFS_CTRL: rd_word = {24'h00_0000, psw_r};
			OFS_SP: rd_word = {24'h00_0000, sp_r};
			OFS_PAGE: rd_word = {28'h000_0000, xwr_flash_r, page_r};
			OFS_STAT: rd_word = {16'h0000, ptr, bank_base};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// status word: bank select bits
	// one bank active
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			psw_r <= PSW_RESET;
		end else if (wr_stb && wr_ofs == OFS_CTRL) begin
			psw_r <= wr_data[7:0];
		end
	end

	// page field and external-write target; flash mode is a simple flag
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			page_r <= PAGE_RESET;
			xwr_flash_r <= 1'b0;
		end else if (wr_stb && wr_ofs == OFS_PAGE) begin
			page_r <= wr_data[2:0];
			xwr_flash_r <= wr_data[3];
		end
	end

	////////////////////////////////////////////////////////////////////
	// address formation
	// four banks of eight
	assign bank_base = {3'b000, psw_r[BANK_HI_POS], psw_r[BANK_LO_POS], 3'b000};
	assign ptr = iram[bank_base + {7'h00, req.use_idx_one}];

	// effective internal address and routing decision
	always_comb begin
		eff_addr = req.addr;
		to_sfr = 1'b0;
		sp_nxt = sp_r;
		case (req.kind)
			ACC_DIRECT: begin
				to_sfr = (req.addr > DIRECT_TOP);
			end
			ACC_INDIRECT: begin
				eff_addr = ptr;
			end
			ACC_BIT: begin
				to_sfr = req.addr[7];
				eff_addr = bit_to_byte(req.addr);
			end
			ACC_PUSH: begin
				sp_nxt = sp_r + 8'h01;
				eff_addr = sp_r + 8'h01;
			end
			ACC_POP: begin
				sp_nxt = sp_r - 8'h01;
				eff_addr = sp_r;
			end
			default: begin
				eff_addr = req.addr;
			end
		endcase
	end

	assign bit_byte = iram[eff_addr];
	assign bit_val = bit_byte[req.addr[2:0]];

	// write data: bit writes merge into the byte
	always_comb begin
		iram_wdata = req.wdata;
		if (req.kind == ACC_BIT) begin
			iram_wdata = bit_byte;
			iram_wdata[req.addr[2:0]] = req.wdata[0];
		end
	end

	// upper half only through indirect or stack
	assign iram_wr = req.wr && !to_sfr && (req.kind == ACC_DIRECT || req.kind == ACC_INDIRECT
		|| req.kind == ACC_BIT || req.kind == ACC_PUSH);

	////////////////////////////////////////////////////////////////////
	// stack pointer, writable from the bus
	// reset value 0x07
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sp_r <= SP_RESET;
		end else if (wr_stb && wr_ofs == OFS_SP) begin
			sp_r <= wr_data[7:0];
		end else if (req.kind == ACC_PUSH || req.kind == ACC_POP) begin
			sp_r <= sp_nxt;
		end
	end

	// internal RAM store; not cleared by reset
	always_ff @(posedge core_clk) begin
		if (iram_wr) begin
			iram[eff_addr] <= iram_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// extended space
	// page supplies upper byte bits 10:8, bits 15:11 zero
	assign xa = req.ptr16 ? req.xaddr : {5'h00, page_r, req.addr};

	// only external moves reach extended_data_ram; flash mode diverts writes
	always_ff @(posedge core_clk) begin
		if (req.kind == ACC_XMOVE && req.wr && !xwr_flash_r && xa < 16'(EXTENDED_DATA_RAM_DEPTH)) begin
			extended_data_ram[xa[EXTENDED_DATA_RAM_AW-1:0]] <= req.wdata;
		end
	end

	// response; no fetch port exists on data memory, flash addr 16 bits
	always_comb begin
		resp_nxt = '0;
		resp_nxt.valid = (req.kind != ACC_NONE);
		case (req.kind)
			ACC_XMOVE: begin
				resp_nxt.rdata = (xa < 16'(EXTENDED_DATA_RAM_DEPTH)) ? extended_data_ram[xa[EXTENDED_DATA_RAM_AW-1:0]] : 8'h00;
				resp_nxt.flash_wr = req.wr && xwr_flash_r;
				resp_nxt.flash_addr = xa;
			end
			ACC_BIT: begin
				// special-register bits live outside this block, so they read zero here
				resp_nxt.rdata = {7'h00, bit_val && !to_sfr};
				resp_nxt.sfr_sel = to_sfr;
				resp_nxt.sfr_addr = {req.addr[7:3], 3'b000};
			end
			default: begin
				resp_nxt.rdata = to_sfr ? 8'h00 : iram[eff_addr];
				resp_nxt.sfr_sel = to_sfr;
				resp_nxt.sfr_addr = to_sfr ? req.addr : 8'h00;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			resp <= '0;
		end else begin
			resp <= resp_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	// all but the reset check sleep while reset is low
	property p_sp_reset;
		@(posedge core_clk) !rst_n |=> sp_r == SP_RESET;
	endproperty
	a_sp_reset: assert property (p_sp_reset) else $error("stack pointer reset wrong");

	property p_push;
		@(posedge core_clk) disable iff (!rst_n)
		(req.kind == ACC_PUSH && !(wr_stb && wr_ofs == OFS_SP)) |=> sp_r == $past(sp_r) + 8'h01;
	endproperty
	a_push: assert property (p_push) else $error("push did not increment");

	property p_direct_sfr;
		@(posedge core_clk) disable iff (!rst_n)
		(req.kind == ACC_DIRECT && req.addr[7]) |=> resp.sfr_sel;
	endproperty
	a_direct_sfr: assert property (p_direct_sfr) else $error("direct high not routed");

	property p_indirect_ram;
		@(posedge core_clk) disable iff (!rst_n)
		req.kind == ACC_INDIRECT |=> !resp.sfr_sel
			&& ($past(req.wr) || resp.rdata == $past(iram[ptr]));
	endproperty
	a_indirect_ram: assert property (p_indirect_ram) else $error("indirect sent out");

	property p_bank;
		@(posedge core_clk) disable iff (!rst_n)
		bank_base == {3'b000, psw_r[BANK_HI_POS:BANK_LO_POS], 3'b000} && bank_base < 8'h20;
	endproperty
	a_bank: assert property (p_bank) else $error("bank base wrong");

	property p_flash;
		@(posedge core_clk) disable iff (!rst_n)
		(req.kind == ACC_XMOVE && req.wr && xwr_flash_r) |=> resp.flash_wr;
	endproperty
	a_flash: assert property (p_flash) else $error("flash write missing");

	property p_page;
		@(posedge core_clk) disable iff (!rst_n)
		(req.kind == ACC_XMOVE && !req.ptr16) |=> resp.flash_addr[15:8] == {5'h00, $past(page_r)};
	endproperty
	a_page: assert property (p_page) else $error("page byte wrong");

	property p_bitsel;
		@(posedge core_clk) disable iff (!rst_n)
		(req.kind == ACC_BIT && !req.addr[7]) |=> !resp.sfr_sel && resp.rdata[7:1] == 7'h00;
	endproperty
	a_bitsel: assert property (p_bitsel) else $error("bit access wrong");

	property p_pop;
		@(posedge core_clk) disable iff (!rst_n)
		(req.kind == ACC_POP && !(wr_stb && wr_ofs == OFS_SP)) |=> sp_r == $past(sp_r) - 8'h01;
	endproperty
	a_pop: assert property (p_pop) else $error("pop did not decrement");

	property p_direct_hold;
		@(posedge core_clk) disable iff (!rst_n)
		(req.kind == ACC_DIRECT && req.addr[7]) |-> !iram_wr;
	endproperty
	a_direct_hold: assert property (p_direct_hold) else $error("direct high wrote RAM");

	property p_xmove_ram;
		@(posedge core_clk) disable iff (!rst_n)
		req.kind == ACC_XMOVE |-> !iram_wr;
	endproperty
	a_xmove_ram: assert property (p_xmove_ram) else $error("external move wrote RAM");

	property p_valid;
		@(posedge core_clk) disable iff (!rst_n)
		1'b1 |=> resp.valid == ($past(req.kind) != ACC_NONE);
	endproperty
	a_valid: assert property (p_valid) else $error("answer valid wrong");

	property p_bit_sfr;
		@(posedge core_clk) disable iff (!rst_n)
		(req.kind == ACC_BIT && req.addr[7]) |=> resp.sfr_sel && resp.rdata == 8'h00
			&& resp.sfr_addr == {$past(req.addr[7:3]), 3'b000};
	endproperty
	a_bit_sfr: assert property (p_bit_sfr) else $error("high bit access wrong");

	property p_flash_off;
		@(posedge core_clk) disable iff (!rst_n)
		(req.kind == ACC_XMOVE && req.wr && !xwr_flash_r) |=> !resp.flash_wr;
	endproperty
	a_flash_off: assert property (p_flash_off) else $error("flash write unexpected");
endmodule

// ===== hdl/dmem_pkg.sv
// Purpose: shared constants and carriers for the data-memory decoder
// Assumes: one 50 MHz clock, synchronous active-low reset
// Notes: AHB-Lite register offsets are byte addresses
package dmem_pkg;
	// register map (word aligned)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SP = 8'h04;
	localparam logic [7:0] OFS_PAGE = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	// field positions and reset values
	localparam int BANK_LO_POS = 3;
	localparam int BANK_HI_POS = 4;
	localparam int XWR_FLASH_POS = 0;
	localparam logic [7:0] SP_RESET = 8'h07;
	localparam logic [7:0] PSW_RESET = 8'h00;
	localparam logic [2:0] PAGE_RESET = 3'h0;
	localparam logic [6:0] UPPER_BIT = 7'h40;
	localparam logic [7:0] BIT_BASE = 8'h20;
	localparam int EXTENDED_DATA_RAM_DEPTH = 2048;
	localparam int EXTENDED_DATA_RAM_AW = 11;
	localparam logic [7:0] DIRECT_TOP = 8'h7F;

	// access kinds driven by the instruction unit
	typedef enum logic [2:0] {
		ACC_NONE,
		ACC_DIRECT,
		ACC_INDIRECT,
		ACC_BIT,
		ACC_PUSH,
		ACC_POP,
		ACC_XMOVE
	} acc_kind_e;

	typedef struct packed {
		acc_kind_e kind;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic use_idx_one;
		logic ptr16;
		logic [15:0] xaddr;
	} dreq_s;

	typedef struct packed {
		logic valid;
		logic [7:0] rdata;
		logic sfr_sel;
		logic [7:0] sfr_addr;
		logic flash_wr;
		logic [15:0] flash_addr;
	} dresp_s;
endpackage
